// ---- include/mmd_pkg.sv ----
// Package: memory map, vector table and special-register map constants for the decoder
`default_nettype none
package mmd_pkg;
	// Widths
	localparam int unsigned ADDR_W   = 16;
	localparam int unsigned FLASH_AW = 13;  // 8 kB bank
	localparam int unsigned NUM_IRQ  = 10;

	// Program space
	localparam logic [15:0] FLASH_LO_BASE   = 16'h0000;
	localparam logic [15:0] FLASH_HI_BASE   = 16'h2000;
	localparam logic [15:0] FLASH_RSVD_BASE = 16'h3fc0;
	localparam logic [15:0] FLASH_RSVD_TOP  = 16'h3fff;
	localparam logic [15:0] XROM_BASE       = 16'h4000;
	localparam logic [15:0] RESET_VEC_TOP   = 16'h0002;
	localparam logic [15:0] IRQ_VEC_BASE    = 16'h0003;
	localparam logic [15:0] IRQ_VEC_TOP     = 16'h006a;
	localparam logic [15:0] IRQ_SLOT_UNUSED = 16'h0033;

	// Data space
	localparam logic [15:0] IRAM_HI_BASE = 16'h0080;
	localparam logic [15:0] XRAM_BASE    = 16'h0100;

	// Special registers; bit i of a map stands for address 80h + i
	localparam logic [7:0]   SFR_VERSION  = 8'hb2;
	localparam logic [7:0]   VERSION_ID   = 8'h5a;  // Arbitrary value
	localparam logic [2:0]   SFR_BIT_COL  = 3'h0;
	localparam logic [7:0]   SFR_NONE_VAL = 8'h00;
	localparam logic [127:0] SFR_IMPL_MAP = 128'h41013d013d013d2f0105010103037fff;
	localparam logic [127:0] SFR_RSVD_MAP = 128'h00000000000000100c18000000008000;

	// Interrupt sources in natural priority order: ext a, timer 0, ext b, timer 1,
	// serial 0, timer 2, serial 1, flash done, converter, watchdog
	localparam logic [NUM_IRQ-1:0][15:0] IRQ_VEC = {
		16'h0063, 16'h004b, 16'h0043, 16'h003b, 16'h002b,
		16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};
	localparam logic [NUM_IRQ-1:0][3:0] IRQ_PRIO = {
		4'hc, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
	localparam logic [3:0] PRIO_NONE = 4'h0;

	// Instruction timing: four master clocks per machine cycle
	localparam logic [1:0] PHASE_LAST = 2'h3;

	typedef enum logic [2:0] {
		CODE_NONE, CODE_FLASH_LO, CODE_FLASH_HI, CODE_EXT_ROM, CODE_DENIED
	} mmd_code_e;

	typedef enum logic [2:0] {
		DATA_NONE, DATA_IRAM_LO, DATA_SFR, DATA_IRAM_HI, DATA_EXT_RAM
	} mmd_data_e;
endpackage
`default_nettype wire

// ---- include/mmd_irq_if.sv ----
// Interface: pending interrupts in, chosen source out, between decoder and arbiter
`default_nettype none
interface mmd_irq_if;
	logic [mmd_pkg::NUM_IRQ-1:0] pending;
	logic [mmd_pkg::NUM_IRQ-1:0] level_hi;
	logic                        valid;
	logic [3:0]                  index;

	modport arbiter (input pending, input level_hi, output valid, output index);
	modport core (output pending, output level_hi, input valid, input index);
endinterface
`default_nettype wire

// ---- hdl/mmd_irq_arb.sv ----
// Interrupt arbiter: programmed level first, then highest natural priority
`default_nettype none
module mmd_irq_arb (
	mmd_irq_if.arbiter irq
);
	// Lowest set index wins; index order equals natural priority order
	function automatic logic [4:0] first_set(input logic [mmd_pkg::NUM_IRQ-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = mmd_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	logic [mmd_pkg::NUM_IRQ-1:0] hi_req;
	wire  [4:0]                  hi_pick;
	wire  [4:0]                  any_pick;

	// Sources pending at the high programmed level
	genvar g;
	generate
		for (g = 0; g < mmd_pkg::NUM_IRQ; g++) begin : g_hi
			assign hi_req[g] = irq.pending[g] & irq.level_hi[g];
		end
	endgenerate

	// High level beats low; within a level the smaller number wins
	assign hi_pick   = first_set(hi_req);
	assign any_pick  = first_set(irq.pending);
	assign irq.valid = any_pick[4];
	assign irq.index = hi_pick[4] ? hi_pick[3:0] : any_pick[3:0];
endmodule
`default_nettype wire

// ---- hdl/mmd_decoder.sv ----
// Memory map decoder: program and data region selects, vectors and cycle timing
`default_nettype none
module mmd_decoder (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              reset_pin,
	input  wire logic              external_program_select,
	input  wire logic              code_req,
	input  wire logic [15:0]       code_addr,
	input  wire logic              data_req,
	input  wire logic [15:0]       data_addr,
	input  wire logic              data_indirect,
	input  wire logic              data_bit_op,
	input  wire logic              ext_irq_line_a,
	input  wire logic              ext_irq_line_b,
	input  wire logic [7:0]        periph_irq,
	input  wire logic [9:0]        irq_level_hi,
	output var  mmd_pkg::mmd_code_e code_region_q,
	output logic [12:0]            code_bank_addr_q,
	output logic                   code_denied_q,
	output logic                   code_reset_vec_q,
	output logic                   code_irq_vec_q,
	output var  mmd_pkg::mmd_data_e data_region_q,
	output logic [7:0]             data_local_addr_q,
	output logic                   sfr_bit_ok_q,
	output logic                   sfr_bit_fault_q,
	output logic                   sfr_unimpl_q,
	output logic                   sfr_reserved_q,
	output logic [7:0]             sfr_rdata_q,
	output logic                   sfr_rdata_valid_q,
	output logic                   irq_valid_q,
	output logic [15:0]            irq_vector_q,
	output logic [3:0]             irq_prio_q,
	output logic [1:0]             cycle_phase_q,
	output logic                   instr_end_q,
	output logic                   core_reset_q
);
	// Either reset source holds the block; the pin is active high
	wire rst_int = !rst_n || reset_pin;

	// Program space decode, all from the current address
	wire                 code_in_low;
	wire                 code_in_rsvd;
	wire                 code_in_hi_bank;
	mmd_pkg::mmd_code_e  code_sel;
	assign code_in_low     = code_addr < mmd_pkg::XROM_BASE;
	assign code_in_rsvd    = (code_addr >= mmd_pkg::FLASH_RSVD_BASE) &&
	                         (code_addr <= mmd_pkg::FLASH_RSVD_TOP);
	assign code_in_hi_bank = code_addr >= mmd_pkg::FLASH_HI_BASE;
	assign code_sel =
		!code_req                 ? mmd_pkg::CODE_NONE     :
		!external_program_select  ? mmd_pkg::CODE_EXT_ROM  :
		!code_in_low              ? mmd_pkg::CODE_EXT_ROM  :
		code_in_rsvd              ? mmd_pkg::CODE_DENIED   :
		code_in_hi_bank           ? mmd_pkg::CODE_FLASH_HI :
		                            mmd_pkg::CODE_FLASH_LO;

	// Vector area markers; only meaningful in the lower flash bank
	wire code_is_reset_vec;
	wire code_is_irq_vec;
	assign code_is_reset_vec = (code_sel == mmd_pkg::CODE_FLASH_LO) &&
	                           (code_addr <= mmd_pkg::RESET_VEC_TOP);
	assign code_is_irq_vec   = (code_sel == mmd_pkg::CODE_FLASH_LO) &&
	                           (code_addr >= mmd_pkg::IRQ_VEC_BASE) &&
	                           (code_addr <= mmd_pkg::IRQ_VEC_TOP);

	// Data space decode; the addressing mode only matters in the upper block
	wire                 data_in_low;
	wire                 data_internal;
	mmd_pkg::mmd_data_e  data_sel;
	assign data_in_low   = data_addr < mmd_pkg::IRAM_HI_BASE;
	assign data_internal = data_addr < mmd_pkg::XRAM_BASE;
	assign data_sel =
		!data_req      ? mmd_pkg::DATA_NONE    :
		!data_internal ? mmd_pkg::DATA_EXT_RAM :
		data_in_low    ? mmd_pkg::DATA_IRAM_LO :
		data_indirect  ? mmd_pkg::DATA_IRAM_HI :
		                 mmd_pkg::DATA_SFR;

	// Register window checks; maps are indexed by the low seven address bits
	wire       sfr_hit;
	wire [6:0] sfr_idx;
	wire       sfr_impl;
	wire       sfr_rsvd;
	wire       sfr_col0;
	wire       sfr_is_version;
	assign sfr_hit        = data_sel == mmd_pkg::DATA_SFR;
	assign sfr_idx        = data_addr[6:0];
	assign sfr_impl       = mmd_pkg::SFR_IMPL_MAP[sfr_idx];
	assign sfr_rsvd       = mmd_pkg::SFR_RSVD_MAP[sfr_idx];
	assign sfr_col0       = data_addr[2:0] == mmd_pkg::SFR_BIT_COL;
	assign sfr_is_version = sfr_hit && (data_addr[7:0] == mmd_pkg::SFR_VERSION);

	// Unassigned registers answer a fixed zero rather than stale data
	wire [7:0] sfr_rdata_d;
	assign sfr_rdata_d = sfr_is_version ? mmd_pkg::VERSION_ID : mmd_pkg::SFR_NONE_VAL;

	// Interrupt arbitration; source order follows natural priority
	mmd_irq_if irq_bus ();
	assign irq_bus.pending  = {periph_irq[7:1], ext_irq_line_b, periph_irq[0], ext_irq_line_a};
	assign irq_bus.level_hi = irq_level_hi;

	mmd_irq_arb u_arb (
		.irq (irq_bus)
	);

	// Vector and priority lookup; the range guard keeps a stray index harmless
	wire        irq_idx_ok;
	wire [15:0] irq_vector_d;
	wire [3:0]  irq_prio_d;
	assign irq_idx_ok   = irq_bus.valid && (irq_bus.index < 4'(mmd_pkg::NUM_IRQ));
	assign irq_vector_d = irq_idx_ok ? mmd_pkg::IRQ_VEC[irq_bus.index] :
	                                   mmd_pkg::IRQ_VEC_BASE;
	assign irq_prio_d   = irq_idx_ok ? mmd_pkg::IRQ_PRIO[irq_bus.index] :
	                                   mmd_pkg::PRIO_NONE;

	// Four-phase machine cycle counter
	wire [1:0] cycle_phase_d;
	assign cycle_phase_d = (cycle_phase_q == mmd_pkg::PHASE_LAST) ? 2'h0 :
	                       2'(cycle_phase_q + 2'h1);

	// Reset status and cycle timing
	always_ff @(posedge clock) begin
		core_reset_q <= rst_int;
		if (rst_int) begin
			cycle_phase_q <= 2'h0;
			instr_end_q   <= 1'b0;
		end else begin
			cycle_phase_q <= cycle_phase_d;
			instr_end_q   <= cycle_phase_d == mmd_pkg::PHASE_LAST;
		end
	end

	// Program side outputs; registered so the core sees clean selects
	always_ff @(posedge clock) begin
		if (rst_int) begin
			code_region_q    <= mmd_pkg::CODE_NONE;
			code_bank_addr_q <= 13'h0000;
			code_denied_q    <= 1'b0;
			code_reset_vec_q <= 1'b0;
			code_irq_vec_q   <= 1'b0;
		end else begin
			code_region_q    <= code_sel;
			code_bank_addr_q <= code_addr[mmd_pkg::FLASH_AW-1:0];
			code_denied_q    <= code_sel == mmd_pkg::CODE_DENIED;
			code_reset_vec_q <= code_is_reset_vec;
			code_irq_vec_q   <= code_is_irq_vec;
		end
	end

	// Data side outputs
	always_ff @(posedge clock) begin
		if (rst_int) begin
			data_region_q     <= mmd_pkg::DATA_NONE;
			data_local_addr_q <= 8'h00;
		end else begin
			data_region_q     <= data_sel;
			data_local_addr_q <= data_addr[7:0];
		end
	end

	// Register window status; bit work outside column zero is refused
	always_ff @(posedge clock) begin
		if (rst_int) begin
			sfr_bit_ok_q      <= 1'b0;
			sfr_bit_fault_q   <= 1'b0;
			sfr_unimpl_q      <= 1'b0;
			sfr_reserved_q    <= 1'b0;
			sfr_rdata_q       <= 8'h00;
			sfr_rdata_valid_q <= 1'b0;
		end else begin
			sfr_bit_ok_q      <= sfr_hit && data_bit_op && sfr_col0;
			sfr_bit_fault_q   <= sfr_hit && data_bit_op && !sfr_col0;
			sfr_unimpl_q      <= sfr_hit && !sfr_impl && !sfr_rsvd;
			sfr_reserved_q    <= sfr_hit && sfr_rsvd;
			sfr_rdata_q       <= sfr_rdata_d;
			sfr_rdata_valid_q <= sfr_is_version;
		end
	end

	// Chosen interrupt; a low slot number is not a priority, the table is
	always_ff @(posedge clock) begin
		if (rst_int) begin
			irq_valid_q  <= 1'b0;
			irq_vector_q <= mmd_pkg::IRQ_VEC_BASE;
			irq_prio_q   <= mmd_pkg::PRIO_NONE;
		end else begin
			irq_valid_q  <= irq_idx_ok;
			irq_vector_q <= irq_vector_d;
			irq_prio_q   <= irq_prio_d;
		end
	end

	// Checks on the decoded outputs
	a_reset_pin_holds: assert property (@(posedge clock)
		reset_pin |=> core_reset_q && (cycle_phase_q == 2'h0) && !irq_valid_q)
		else $error("reset pin did not hold the block");

	a_flash_banks: assert property (@(posedge clock) disable iff (rst_int)
		code_req && external_program_select && (code_addr < 16'h3fc0) |=>
		(code_region_q == ($past(code_addr) < 16'h2000 ? mmd_pkg::CODE_FLASH_LO
		                                               : mmd_pkg::CODE_FLASH_HI)) &&
		(code_bank_addr_q == $past(code_addr[12:0])))
		else $error("flash bank select wrong");

	a_rsvd_denied: assert property (@(posedge clock) disable iff (rst_int)
		code_req && external_program_select && (code_addr[15:6] == 10'h0ff) |=>
		code_denied_q && (code_region_q == mmd_pkg::CODE_DENIED))
		else $error("reserved flash top reached");

	a_ext_rom_route: assert property (@(posedge clock) disable iff (rst_int)
		code_req && (!external_program_select || code_addr[15:14] != 2'h0) |=>
		(code_region_q == mmd_pkg::CODE_EXT_ROM) && !code_denied_q)
		else $error("fetch not sent to external ROM");

	a_vector_area: assert property (@(posedge clock) disable iff (rst_int)
		code_req && external_program_select |=>
		(code_reset_vec_q == ($past(code_addr) <= 16'h0002)) &&
		(code_irq_vec_q == ($past(code_addr) >= 16'h0003 && $past(code_addr) <= 16'h006a)))
		else $error("vector area marker wrong");

	a_data_regions: assert property (@(posedge clock) disable iff (rst_int)
		data_req |=> data_region_q ==
		($past(data_addr) >= 16'h0100 ? mmd_pkg::DATA_EXT_RAM :
		 $past(data_addr) <  16'h0080 ? mmd_pkg::DATA_IRAM_LO :
		 $past(data_indirect)         ? mmd_pkg::DATA_IRAM_HI : mmd_pkg::DATA_SFR))
		else $error("data region select wrong");

	a_ext_line_slots: assert property (@(posedge clock) disable iff (rst_int)
		ext_irq_line_a && (irq_level_hi[0] || !(|irq_level_hi)) |=>
		irq_valid_q && (irq_vector_q == 16'h0003) && (irq_prio_q == 4'h1))
		else $error("line a vector wrong");

	a_line_b_slot: assert property (@(posedge clock) disable iff (rst_int)
		ext_irq_line_b && !ext_irq_line_a && (periph_irq[0] == 1'b0) && !(|irq_level_hi) |=>
		(irq_vector_q == 16'h0013) && (irq_prio_q == 4'h3))
		else $error("line b vector wrong");

	a_watchdog_slot: assert property (@(posedge clock) disable iff (rst_int)
		periph_irq[7] && irq_level_hi[9] && !(|(irq_bus.pending[8:0] & irq_level_hi[8:0])) |=>
		(irq_vector_q == 16'h0063) && (irq_prio_q == 4'hc))
		else $error("watchdog vector wrong");

	a_timer0_slot: assert property (@(posedge clock) disable iff (rst_int)
		periph_irq[0] && !ext_irq_line_a && !(|irq_level_hi) |=>
		irq_valid_q && (irq_vector_q == 16'h000b) && (irq_prio_q == 4'h2))
		else $error("timer 0 vector wrong");

	a_serial0_slot: assert property (@(posedge clock) disable iff (rst_int)
		periph_irq[2] && !(|{periph_irq[1:0], ext_irq_line_b, ext_irq_line_a}) &&
		!(|irq_level_hi) |=> (irq_vector_q == 16'h0023) && (irq_prio_q == 4'h5))
		else $error("serial 0 vector wrong");

	a_serial1_slot: assert property (@(posedge clock) disable iff (rst_int)
		periph_irq[4] && irq_level_hi[6] && !(|(irq_bus.pending[5:0] & irq_level_hi[5:0])) |=>
		(irq_vector_q == 16'h003b) && (irq_prio_q == 4'h7))
		else $error("serial 1 vector wrong");

	a_flash_done_slot: assert property (@(posedge clock) disable iff (rst_int)
		periph_irq[5] && irq_level_hi[7] && !(|(irq_bus.pending[6:0] & irq_level_hi[6:0])) |=>
		(irq_vector_q == 16'h0043) && (irq_prio_q == 4'h8))
		else $error("flash done vector wrong");

	// The level must be taken from the same cycle as the pick, not the current one
	a_level_first: assert property (@(posedge clock) disable iff (rst_int)
		irq_valid_q |-> (irq_vector_q != 16'h0033) &&
		(!$past(|(irq_bus.pending & irq_level_hi)) || $past(irq_level_hi[irq_bus.index])))
		else $error("interrupt level order broken");

	a_bit_column: assert property (@(posedge clock) disable iff (rst_int)
		sfr_bit_ok_q |-> ($past(data_addr[2:0]) == 3'h0) && !sfr_bit_fault_q)
		else $error("bit access outside column zero");

	a_version_read: assert property (@(posedge clock) disable iff (rst_int)
		data_req && !data_indirect && (data_addr == 16'h00b2) |=>
		sfr_rdata_valid_q && (sfr_rdata_q == mmd_pkg::VERSION_ID))
		else $error("version register not returned");

	a_reserved_flag: assert property (@(posedge clock) disable iff (rst_int)
		sfr_reserved_q |-> !sfr_unimpl_q && !sfr_rdata_valid_q && (sfr_rdata_q == 8'h00))
		else $error("reserved register answered");

	a_four_clock_cycle: assert property (@(posedge clock) disable iff (rst_int)
		instr_end_q |=> !instr_end_q [*3] ##1 instr_end_q)
		else $error("machine cycle not four clocks");
endmodule
`default_nettype wire

// ---- bench/mmd_core_model.sv ----
// Core-side model: presents fetch and data requests to the decoder
`default_nettype none
module mmd_core_model (
	input  wire logic        clock,
	input  wire logic        go_code,
	input  wire logic [15:0] go_code_addr,
	input  wire logic        go_data,
	input  wire logic [15:0] go_data_addr,
	output logic             code_req,
	output logic [15:0]      code_addr,
	output logic             data_req,
	output logic [15:0]      data_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] code_idle_q = 16'h5a5a;
	logic [15:0] data_idle_q = 16'ha5a5;
	// Idle address lines flip every cycle, so a decoder that ignores the strobe is caught
	always_ff @(posedge clock) begin
		code_idle_q <= ~code_addr;
		data_idle_q <= ~data_addr;
	end
	// Strobes pass straight through; the bench changes them at the falling edge
	assign code_req  = go_code;
	assign code_addr = go_code ? go_code_addr : code_idle_q;
	assign data_req  = go_data;
	assign data_addr = go_data ? go_data_addr : data_idle_q;
endmodule
`default_nettype wire

// ---- bench/tb_mmd_decoder.sv ----
// Testbench: random and corner accesses, interrupt choice, cycle phase, reset
`default_nettype none
module tb_mmd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, reset_pin, ea_pin, go_code, go_data, ind, bop, line_a, line_b;
	logic [15:0] go_code_addr, go_data_addr, code_addr, data_addr;
	logic code_req, data_req;
	logic [7:0] periph;
	logic [9:0] lvl;
	mmd_pkg::mmd_code_e code_region_q;
	mmd_pkg::mmd_data_e data_region_q;
	logic [12:0] code_bank_addr_q;
	logic [7:0] data_local_addr_q, sfr_rdata_q;
	logic [15:0] irq_vector_q;
	logic [3:0] irq_prio_q;
	logic [1:0] cycle_phase_q, ph;
	logic code_denied_q, code_reset_vec_q, code_irq_vec_q, sfr_bit_ok_q, sfr_bit_fault_q;
	logic sfr_unimpl_q, sfr_reserved_q, sfr_rdata_valid_q, irq_valid_q, instr_end_q;
	logic core_reset_q;
	logic [31:0] rng, r, s;
	int fail_count, checked;
	logic [15:0] CA[12] = '{16'h0000, 16'h0002, 16'h0003, 16'h006a, 16'h006b, 16'h1fff,
		16'h2000, 16'h3fbf, 16'h3fc0, 16'h3fff, 16'h4000, 16'hffff};
	logic [15:0] DA[12] = '{16'h0000, 16'h007f, 16'h0080, 16'h0088, 16'h0089, 16'h008f,
		16'h00b2, 16'h00b3, 16'h00c4, 16'h00ff, 16'h0100, 16'hffff};
	logic [15:0] VEC[10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
		16'h003b, 16'h0043, 16'h004b, 16'h0063};

	mmd_core_model i_mmd_core_model (.clock(clock), .go_code(go_code),
		.go_code_addr(go_code_addr), .go_data(go_data), .go_data_addr(go_data_addr),
		.code_req(code_req), .code_addr(code_addr), .data_req(data_req),
		.data_addr(data_addr));
	mmd_decoder i_mmd_decoder (.clock(clock), .rst_n(rst_n), .reset_pin(reset_pin),
		.external_program_select(ea_pin), .code_req(code_req), .code_addr(code_addr),
		.data_req(data_req), .data_addr(data_addr), .data_indirect(ind), .data_bit_op(bop),
		.ext_irq_line_a(line_a), .ext_irq_line_b(line_b), .periph_irq(periph),
		.irq_level_hi(lvl), .code_region_q(code_region_q), .code_bank_addr_q(code_bank_addr_q),
		.code_denied_q(code_denied_q), .code_reset_vec_q(code_reset_vec_q),
		.code_irq_vec_q(code_irq_vec_q), .data_region_q(data_region_q),
		.data_local_addr_q(data_local_addr_q), .sfr_bit_ok_q(sfr_bit_ok_q),
		.sfr_bit_fault_q(sfr_bit_fault_q), .sfr_unimpl_q(sfr_unimpl_q),
		.sfr_reserved_q(sfr_reserved_q), .sfr_rdata_q(sfr_rdata_q),
		.sfr_rdata_valid_q(sfr_rdata_valid_q), .irq_valid_q(irq_valid_q),
		.irq_vector_q(irq_vector_q), .irq_prio_q(irq_prio_q), .cycle_phase_q(cycle_phase_q),
		.instr_end_q(instr_end_q), .core_reset_q(core_reset_q));

	// Master clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic mmd_pkg::mmd_code_e exp_code(input logic ea, input logic [15:0] a);
		if (!ea || a >= 16'h4000) return mmd_pkg::CODE_EXT_ROM;
		if (a >= 16'h3fc0) return mmd_pkg::CODE_DENIED;
		return (a < 16'h2000) ? mmd_pkg::CODE_FLASH_LO : mmd_pkg::CODE_FLASH_HI;
	endfunction

	function automatic mmd_pkg::mmd_data_e exp_data(input logic in_d, input logic [15:0] a);
		if (a >= 16'h0100) return mmd_pkg::DATA_EXT_RAM;
		if (a < 16'h0080) return mmd_pkg::DATA_IRAM_LO;
		return in_d ? mmd_pkg::DATA_IRAM_HI : mmd_pkg::DATA_SFR;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One code and one data access in the same cycle, checked one edge later
	task automatic step(input logic cr, input logic ea, input logic [15:0] ca,
		input logic dr, input logic [15:0] da, input logic in_d, input logic bo);
		logic lo, sfr;
		@(negedge clock);
		go_code = cr;
		ea_pin = ea;
		go_code_addr = ca;
		go_data = dr;
		go_data_addr = da;
		ind = in_d;
		bop = bo;
		@(posedge clock);
		#1;
		lo = cr && ea && ca < 16'h2000;
		sfr = dr && exp_data(in_d, da) == mmd_pkg::DATA_SFR;
		check(32'(code_region_q), cr ? 32'(exp_code(ea, ca)) : 32'(mmd_pkg::CODE_NONE));
		check(32'(code_denied_q), 32'(cr && ea && ca >= 16'h3fc0 && ca < 16'h4000));
		if (cr) check(32'(code_bank_addr_q), 32'(ca[12:0]));
		check(32'(code_reset_vec_q), 32'(lo && ca <= 16'h0002));
		check(32'(code_irq_vec_q), 32'(lo && ca >= 16'h0003 && ca <= 16'h006a));
		check(32'(data_region_q),
			dr ? 32'(exp_data(in_d, da)) : 32'(mmd_pkg::DATA_NONE));
		if (dr) check(32'(data_local_addr_q), 32'(da[7:0]));
		check(32'(sfr_bit_ok_q), 32'(sfr && bo && da[2:0] == 3'h0));
		check(32'(sfr_bit_fault_q), 32'(sfr && bo && da[2:0] != 3'h0));
		check(32'(sfr_reserved_q), 32'(sfr && mmd_pkg::SFR_RSVD_MAP[da[6:0]]));
		check(32'(sfr_unimpl_q), 32'(sfr && !mmd_pkg::SFR_IMPL_MAP[da[6:0]]
			&& !mmd_pkg::SFR_RSVD_MAP[da[6:0]]));
		check(32'(sfr_rdata_valid_q), 32'(sfr && da[7:0] == 8'hb2));
		check(32'(sfr_rdata_q),
			(sfr && da[7:0] == 8'hb2) ? 32'(mmd_pkg::VERSION_ID) : 32'h0);
	endtask

	// Pending sources in natural order: a, t0, b, t1, s0, t2, s1, flash, converter, watchdog
	task automatic irq_step(input logic [9:0] p, input logic [9:0] l);
		logic [9:0] pool;
		int w;
		@(negedge clock);
		line_a = p[0];
		line_b = p[2];
		periph = {p[9:6], p[5], p[4], p[3], p[1]};
		lvl = l;
		@(posedge clock);
		#1;
		pool = (p & l) != 10'h000 ? (p & l) : p;
		w = 0;
		while (w < 9 && !pool[w]) w++;
		check(32'(irq_valid_q), 32'(p != 10'h000));
		if (p != 10'h000) begin
			check(32'(irq_vector_q), 32'(VEC[w]));
			check(32'(irq_prio_q), (w == 9) ? 32'd12 : 32'(w + 1));
		end
	endtask

	// Hang guard, well beyond the roughly six hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		final_report();
	end

	initial begin
		rng = 32'd27457;
		{rst_n, reset_pin, ea_pin, go_code, go_data, ind, bop, line_a, line_b} = '0;
		{go_code_addr, go_data_addr, periph, lvl} = '0;
		fail_count = 0;
		checked = 0;
		repeat (16) @(posedge clock);
		#1;
		check(32'(core_reset_q), 32'h1);
		check(32'(irq_vector_q), 32'h0003);
		check(32'(cycle_phase_q), 32'h0);
		check(32'(instr_end_q), 32'h0);
		@(negedge clock);
		rst_n = 1'b1;
		@(posedge clock);
		#1;
		check(32'(core_reset_q), 32'h0);
		// Reset leaves phase 0, so the first free edge moves it to 1
		check(32'(cycle_phase_q), 32'h1);
		ph = 2'h1;
		for (int k = 0; k < 9; k++) begin
			@(posedge clock);
			#1;
			ph = ph + 2'h1;
			check(32'(cycle_phase_q), 32'(ph));
			check(32'(instr_end_q), 32'(ph == 2'h3));
		end
		$display("test reset and phase done");
		for (int i = 0; i < 12; i++)
			for (int k = 0; k < 4; k++)
				step(1'b1, k[0], CA[i], 1'b1, DA[i], k[1], k[0]);
		for (int i = 0; i < 300; i++) begin
			r = rnd();
			s = rnd();
			step(r[0] | r[1], r[2], r[31:16], r[3] | r[4], r[5] ? {8'h00, s[7:0]} : s[31:16],
				s[8], s[9]);
		end
		$display("test decode done");
		for (int i = 0; i < 10; i++) begin
			irq_step(10'(1 << i), 10'h000);
			irq_step(10'(1 << i), 10'h3ff);
		end
		irq_step(10'h006, 10'h000);
		irq_step(10'h201, 10'h200);
		irq_step(10'h000, 10'h3ff);
		for (int i = 0; i < 200; i++) begin
			r = rnd();
			irq_step(r[9:0], r[19:10]);
		end
		$display("test interrupts done");
		// Device reset pin held high by the outside for one edge mid-traffic
		@(negedge clock);
		reset_pin = 1'b1;
		go_code = 1'b1;
		go_data = 1'b1;
		@(posedge clock);
		#1;
		check(32'(core_reset_q), 32'h1);
		check(32'(code_region_q), 32'(mmd_pkg::CODE_NONE));
		check(32'(data_region_q), 32'(mmd_pkg::DATA_NONE));
		check(32'(cycle_phase_q), 32'h0);
		@(negedge clock);
		reset_pin = 1'b0;
		@(posedge clock);
		#1;
		check(32'(core_reset_q), 32'h0);
		step(1'b1, 1'b1, 16'h3fc5, 1'b1, 16'h00b2, 1'b0, 1'b0);
		$display("test reset pin done");
		final_report();
	end
endmodule
`default_nettype wire
